/* File: shared/dfe_pkg.sv */
// Purpose: shared constants and types for the two-channel filtered input block
// Assumes: one 100 MHz module clock, parameter bytes written by the head module
// Notes: parameter selectors follow the printed subindex numbers
package dfe_pkg;

  // clock and microsecond tick
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned CYC_PER_US = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // parameter byte selectors
  localparam logic [7:0] SEL_DIAG_EN = 8'h01;
  localparam logic [7:0] SEL_IN0_DELAY = 8'h02;
  localparam logic [7:0] SEL_IN1_DELAY = 8'h03;
  localparam logic [7:0] SEL_RISE_EN = 8'h04;
  localparam logic [7:0] SEL_FALL_EN = 8'h05;

  // reset values
  localparam logic [7:0] RST_DIAG_EN = 8'h00;
  localparam logic [7:0] RST_DELAY = 8'h02;
  localparam logic [7:0] RST_EDGE_EN = 8'h00;

  // diagnostic enable codes
  localparam logic [7:0] DIAG_OFF = 8'h00;
  localparam logic [7:0] DIAG_ON = 8'h40;

  // filter delay codes and their times in microseconds
  localparam logic [7:0] DLY_CODE_1US = 8'h00;
  localparam logic [7:0] DLY_CODE_3US = 8'h02;
  localparam logic [7:0] DLY_CODE_10US = 8'h04;
  localparam logic [7:0] DLY_CODE_86US = 8'h07;
  localparam logic [7:0] DLY_CODE_342US = 8'h09;
  localparam logic [7:0] DLY_CODE_2731US = 8'h0c;
  localparam logic [11:0] DLY_US_1 = 12'd1;
  localparam logic [11:0] DLY_US_3 = 12'd3;
  localparam logic [11:0] DLY_US_10 = 12'd10;
  localparam logic [11:0] DLY_US_86 = 12'd86;
  localparam logic [11:0] DLY_US_342 = 12'd342;
  localparam logic [11:0] DLY_US_2731 = 12'd2731;

  // field positions in per-channel bytes
  localparam int unsigned BIT_IN0 = 0;
  localparam int unsigned BIT_IN1 = 1;
  localparam int unsigned NUM_CH = 2;

  // process interrupt record
  typedef struct packed {
    logic [7:0] edge_flag_byte;
    logic [7:0] captured_input_state;
    logic [15:0] microsecond_stamp;
  } dfe_event_rec_t;

  // parameter write request
  typedef struct packed {
    logic we;
    logic [7:0] sel;
    logic [7:0] wdata;
  } dfe_param_req_t;

endpackage

/* File: rtl/dfe_filter.sv */
// Purpose: one channel of stability filter on a synchronised input
// Assumes: raw input already passed two flip-flops, us_tick one cycle each microsecond
// Notes: resolution is one microsecond tick, so acceptance lands up to one tick late
`timescale 1ns/1ps
module dfe_filter
  import dfe_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing
  input wire logic us_tick,
  input wire logic [CNT_W-1:0] delay_us,
  // signal
  input wire logic raw_in,
  output logic filt_out
);

  logic [CNT_W-1:0] cnt_r;
  logic state_r;

  // any return to the filtered state restarts the count, so short pulses never pass
  // both directions use the same delay
  // first tick may come right after the change, so one extra tick keeps the full delay
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (raw_in == state_r) begin
      cnt_r <= '0;
    end else if (us_tick && cnt_r <= delay_us) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= 1'b0;
    end else if (raw_in != state_r && cnt_r > delay_us) begin
      state_r <= raw_in;
    end
  end

  assign filt_out = state_r;

endmodule

/* File: rtl/dfe_top.sv */
// Purpose: two-channel input front end with glitch filter and edge events
// Assumes: head module writes parameter bytes and acknowledges event records
// Notes: diagnostic output reports a lost process event while enabled
`timescale 1ns/1ps
module dfe_top
  import dfe_pkg::*;
#(
  parameter int unsigned DLY_W = 12
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // field inputs
  input wire logic INPUT_ZERO,
  input wire logic INPUT_ONE,
  // parameter port
  input wire dfe_param_req_t PARAM_REQ,
  output logic [7:0] PARAM_RDATA,
  // process image and indicators
  output logic [7:0] INPUT_STATE,
  output logic [1:0] CH_LED,
  // process event
  output logic EVT_REQ,
  output dfe_event_rec_t EVT_REC,
  input wire logic EVT_ACK,
  // diagnostics
  output logic DIAG_IRQ
);

  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt;
  logic [1:0] filt_prev_r;
  logic [7:0] diag_en_r;
  logic [7:0] dly_code_r [NUM_CH];
  logic [DLY_W-1:0] dly_us [NUM_CH];
  logic [7:0] rise_en_r;
  logic [7:0] fall_en_r;
  logic [7:0] rdata_r;
  logic [7:0] presc_r;
  logic us_tick;
  logic [31:0] us_cnt_r;
  logic [1:0] edges;
  logic evt_any;
  logic slot_free;
  logic evt_req_r;
  dfe_event_rec_t rec_r;
  logic lost_r;
  logic [7:0] state_byte;

  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c == DLY_CODE_1US) || (c == DLY_CODE_3US) || (c == DLY_CODE_10US) ||
              (c == DLY_CODE_86US) || (c == DLY_CODE_342US) || (c == DLY_CODE_2731US);
  endfunction

  function automatic logic [DLY_W-1:0] code_to_us(input logic [7:0] c);
    case (c)
      DLY_CODE_1US: code_to_us = DLY_W'(DLY_US_1);
      DLY_CODE_3US: code_to_us = DLY_W'(DLY_US_3);
      DLY_CODE_10US: code_to_us = DLY_W'(DLY_US_10);
      DLY_CODE_86US: code_to_us = DLY_W'(DLY_US_86);
      DLY_CODE_342US: code_to_us = DLY_W'(DLY_US_342);
      DLY_CODE_2731US: code_to_us = DLY_W'(DLY_US_2731);
      default: code_to_us = DLY_W'(DLY_US_3);
    endcase
  endfunction

  // two-stage synchroniser for the field pins
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {INPUT_ONE, INPUT_ZERO};
      sync2_r <= sync1_r;
    end
  end

  // microsecond prescaler and free-running counter
  always_ff @(posedge MCLK) begin
    if (!RESETN || us_tick) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end
  assign us_tick = (presc_r == 8'(CYC_PER_US - 1));

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      us_cnt_r <= 32'h0;
    end else if (us_tick) begin
      us_cnt_r <= us_cnt_r + 32'h1; // wraps after 2^32-1
    end
  end

  // parameter bytes; the diagnostic byte is trusted to arrive only in stop
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      diag_en_r <= RST_DIAG_EN;
    end else if (PARAM_REQ.we && PARAM_REQ.sel == SEL_DIAG_EN &&
                 (PARAM_REQ.wdata == DIAG_OFF || PARAM_REQ.wdata == DIAG_ON)) begin
      diag_en_r <= PARAM_REQ.wdata;
    end
  end

  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // unknown codes are dropped so the channel keeps a legal delay
      always_ff @(posedge MCLK) begin
        if (!RESETN) begin
          dly_code_r[ch] <= RST_DELAY;
        end else if (PARAM_REQ.we && PARAM_REQ.sel == SEL_IN0_DELAY + 8'(ch) &&
                     code_ok(PARAM_REQ.wdata)) begin
          dly_code_r[ch] <= PARAM_REQ.wdata;
        end
      end
      assign dly_us[ch] = code_to_us(dly_code_r[ch]);

      dfe_filter #(
        .CNT_W(DLY_W)
      ) u_filter (
        .clk(MCLK),
        .rst_n(RESETN),
        .us_tick(us_tick),
        .delay_us(dly_us[ch]),
        .raw_in(sync2_r[ch]),
        .filt_out(filt[ch])
      );
    end
  endgenerate

  // reserved bits are stored but never act
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rise_en_r <= RST_EDGE_EN;
      fall_en_r <= RST_EDGE_EN;
    end else if (PARAM_REQ.we && PARAM_REQ.sel == SEL_RISE_EN) begin
      rise_en_r <= PARAM_REQ.wdata;
    end else if (PARAM_REQ.we && PARAM_REQ.sel == SEL_FALL_EN) begin
      fall_en_r <= PARAM_REQ.wdata;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rdata_r <= 8'h00;
    end else begin
      case (PARAM_REQ.sel)
        SEL_DIAG_EN: rdata_r <= diag_en_r;
        SEL_IN0_DELAY: rdata_r <= dly_code_r[0];
        SEL_IN1_DELAY: rdata_r <= dly_code_r[1];
        SEL_RISE_EN: rdata_r <= rise_en_r;
        SEL_FALL_EN: rdata_r <= fall_en_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // edges come from the filtered state only
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      filt_prev_r <= 2'h0;
    end else begin
      filt_prev_r <= filt;
    end
  end
  assign edges = (filt & ~filt_prev_r & rise_en_r[1:0]) |
                 (~filt & filt_prev_r & fall_en_r[1:0]);
  assign evt_any = |edges;
  assign slot_free = !evt_req_r || EVT_ACK;
  assign state_byte = {6'h00, filt};

  // a new event in the acknowledge cycle still takes the slot
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      evt_req_r <= 1'b0;
    end else if (evt_any && slot_free) begin
      evt_req_r <= 1'b1;
    end else if (EVT_ACK) begin
      evt_req_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rec_r <= '0;
    end else if (evt_any && slot_free) begin
      rec_r.edge_flag_byte <= {6'h00, edges};
      rec_r.captured_input_state <= state_byte;
      rec_r.microsecond_stamp <= us_cnt_r[15:0];
    end
  end

  // an event with the slot busy is lost; cleared once the slot is acknowledged
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      lost_r <= 1'b0;
    end else if (evt_any && !slot_free) begin
      lost_r <= 1'b1;
    end else if (EVT_ACK) begin
      lost_r <= 1'b0;
    end
  end

  assign PARAM_RDATA = rdata_r;
  assign INPUT_STATE = state_byte;
  assign CH_LED = filt;
  assign EVT_REQ = evt_req_r;
  assign EVT_REC = rec_r;
  assign DIAG_IRQ = lost_r && (diag_en_r == DIAG_ON);

endmodule

/* File: testbench/dfe_checker.sv */
// Purpose: port checker for dfe_top
// Assumes: reset low disables every check
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module dfe_checker
  import dfe_pkg::*;
#(
  parameter int unsigned DLY_W = 12
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // observed
  input wire logic INPUT_ZERO,
  input wire logic [7:0] INPUT_STATE,
  input wire logic [1:0] CH_LED,
  input wire logic EVT_REQ,
  input wire dfe_event_rec_t EVT_REC,
  input wire logic EVT_ACK,
  input wire logic DIAG_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  AST_LED: assert property (CH_LED == INPUT_STATE[1:0])
    else $error("indicator differs from state");
  AST_PAD: assert property (INPUT_STATE[7:2] == 6'h00)
    else $error("state upper bits set");
  AST_HOLD: assert property (EVT_REQ && !EVT_ACK |=> EVT_REQ && $stable(EVT_REC))
    else $error("record changed while pending");
  AST_FLAG: assert property (EVT_REQ |-> EVT_REC.edge_flag_byte[7:2] == 6'h00
    && EVT_REC.edge_flag_byte[1:0] != 2'h0) else $error("bad edge flags");
  AST_CAPT: assert property ($rose(EVT_REQ) |->
    EVT_REC.captured_input_state == $past(INPUT_STATE)) else $error("captured state wrong");
  // min delay is 1 us, so 60 quiet cycles always precede a flip
  AST_GLITCH: assert property ($changed(INPUT_STATE[0]) |->
    $past(INPUT_ZERO, 5) == INPUT_STATE[0] && $past(INPUT_ZERO, 60) == INPUT_STATE[0])
    else $error("unfiltered flip");
  AST_DIAG: assert property (DIAG_IRQ |-> EVT_REQ)
    else $error("diag without pending event");
  AST_DROP: assert property (EVT_REQ && EVT_ACK && $stable(INPUT_STATE)
    && $past(INPUT_STATE, 2) == INPUT_STATE |=> !EVT_REQ) else $error("ack ignored");
  cover property ($rose(EVT_REQ));
  cover property (DIAG_IRQ);
  cover property (EVT_REQ && EVT_ACK);
endmodule

bind dfe_top dfe_checker #(.DLY_W(DLY_W)) dfe_checker_i (.MCLK, .RESETN, .INPUT_ZERO,
  .INPUT_STATE, .CH_LED, .EVT_REQ, .EVT_REC, .EVT_ACK, .DIAG_IRQ);

/* File: testbench/dfe_head_model.sv */
// Purpose: head module stand-in that acknowledges event records
// Assumes: acks only while a record is pending
// Notes: lat picks prompt or slow answers
`timescale 1ns/1ps
module dfe_head_model (
  // clock
  input wire logic clk,
  // control
  input wire logic ack_en,
  input wire logic [7:0] lat,
  // event port
  input wire logic evt_req,
  output logic evt_ack
);
  int cnt = 0;
  initial evt_ack = 1'b0;
  always @(posedge clk) begin
    #1;
    if (evt_ack || !evt_req || !ack_en) begin
      evt_ack = 1'b0;
      cnt = 0;
    end else if (cnt >= lat) evt_ack = 1'b1;
    else cnt++;
  end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for dfe_top
// Assumes: inputs change 1 ns after the rising edge
// Notes: delay code 02 keeps random glitches well below acceptance
`timescale 1ns/1ps
module tb_top
  import dfe_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic in0 = 1'b0;
  logic in1 = 1'b0;
  logic ack_en = 1'b1;
  logic [7:0] lat = 8'h01;
  dfe_param_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] st;
  logic [1:0] led;
  logic evt_req;
  logic evt_ack;
  logic diag;
  dfe_event_rec_t rec;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [15:0] lfsr = 16'h004b;
  int reg_m [8] = '{0, 0, 2, 2, 0, 0, 0, 0};
  int codes [8] = '{8'h0c, 8'h09, 8'h07, 8'h04, 8'h00, 8'h05, 8'h02, 8'h0b};
  always #5 MCLK = ~MCLK;
  always @(posedge MCLK) cyc <= RESETN ? cyc + 1 : 0;
  dfe_top dfe_top_i (.MCLK, .RESETN, .INPUT_ZERO(in0), .INPUT_ONE(in1), .PARAM_REQ(req),
    .PARAM_RDATA(rdata), .INPUT_STATE(st), .CH_LED(led), .EVT_REQ(evt_req),
    .EVT_REC(rec), .EVT_ACK(evt_ack), .DIAG_IRQ(diag));
  dfe_head_model dfe_head_model_i (.clk(MCLK), .ack_en, .lat, .evt_req, .evt_ack);
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic final_report;
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // stamp may land one microsecond either side of the bench's count
  task automatic cmp_rec(dfe_event_rec_t got, logic [15:0] fs);
    dfe_event_rec_t e;
    int d;
    e = {fs, 16'(cyc / CYC_PER_US)};
    d = int'(got.microsecond_stamp) - int'(e.microsecond_stamp);
    if (d >= -1 && d <= 1) e.microsecond_stamp = got.microsecond_stamp;
    cmp(got, e);
  endtask
  task automatic wr(logic [7:0] s, logic [7:0] d);
    req = '{we: 1'b1, sel: s, wdata: d};
    tick(1);
    req.we = 1'b0;
    if ((s == 8'h01 && (d == 8'h00 || d == 8'h40)) || s inside {8'h04, 8'h05} ||
      (s inside {8'h02, 8'h03} && d inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c}))
      reg_m[s] = d;
    tick(1);
    cmp(rdata, reg_m[s]);
  endtask
  task automatic rd_all;
    for (int s = 0; s < 8; s++) begin
      req.sel = 8'(s);
      tick(1);
      cmp(rdata, reg_m[s]);
    end
  endtask
  task automatic drive(int ch, logic v);
    logic [7:0] en;
    int i;
    lfsr = lfsr_next(lfsr);
    if (ch == 1) in1 = v; else in0 = v;
    tick(int'(lfsr[5:0]) + 1);
    if (ch == 1) in1 = !v; else in0 = !v;
    tick(150);
    if (ch == 1) in1 = v; else in0 = v;
    en = 8'(v ? reg_m[4] : reg_m[5]);
    for (i = 0; i < 800 && !evt_req; i++) tick(1);
    cmp(evt_req, en[ch]);
    if (en[ch]) cmp_rec(rec, {8'(1 << ch), 6'h00, in1, in0});
    cmp(led, {in1, in0});
    cmp(st, {6'h00, in1, in0});
    for (i = 0; i < 300 && evt_req && ack_en; i++) tick(1);
  endtask
  initial begin
    #300000;
    miscompares++;
    final_report;
  end
  initial begin
    tick(6);
    RESETN = 1'b1;
    rd_all;
    wr(8'h01, 8'h13);
    wr(8'h01, 8'h00);
    wr(8'h01, 8'h40);
    for (int k = 0; k < 8; k++) begin
      wr(8'h02, 8'(codes[k]));
      wr(8'h03, 8'(codes[7 - k]));
    end
    wr(8'h03, 8'h02);
    wr(8'h07, 8'h5a);
    wr(8'h04, 8'hfd);
    wr(8'h05, 8'hfe);
    drive(0, 1'b1);
    drive(1, 1'b1);
    lat = 8'h14;
    drive(0, 1'b0);
    drive(1, 1'b0);
    wr(8'h04, 8'h03);
    wr(8'h02, 8'h00);
    ack_en = 1'b0;
    drive(0, 1'b1);
    in1 = 1'b1;
    tick(800);
    cmp(diag, 1'b1);
    cmp(rec.edge_flag_byte, 8'h01);
    ack_en = 1'b1;
    tick(60);
    cmp({diag, evt_req}, 2'b00);
    RESETN = 1'b0;
    tick(6);
    cmp(st, 8'h00);
    RESETN = 1'b1;
    reg_m = '{0, 0, 2, 2, 0, 0, 0, 0};
    rd_all;
    final_report;
  end
endmodule
